// ==== rtl/usc_defs.svh ====
// register offsets, bit positions, reset values and sizes of the serial status block
`ifndef USC_DEFS_SVH
`define USC_DEFS_SVH
`define USC_ADR_STA 8'h00
`define USC_ADR_TXD 8'h04
`define USC_ADR_RXD 8'h08
`define USC_ADR_MODE 8'h0c
`define USC_DEPTH 3'h4
`define USC_TXISEL_HI 15
`define USC_TXINV 14
`define USC_TXISEL_LO 13
`define USC_BRK 11
`define USC_TXEN 10
`define USC_TXBF 9
`define USC_TX_ALL_EMPTY 8
`define USC_RXISEL_HI 7
`define USC_RXISEL_LO 6
`define USC_ADDR_DETECT_ENABLE 5
`define USC_RX_IDLE_FLAG 4
`define USC_PARITY_ERROR_FLAG 3
`define USC_FRAMING_ERROR_FLAG 2
`define USC_OVERRUN_FLAG 1
`define USC_RXDA 0
`define USC_INFRARED_ENABLE 12
`define USC_PARITY_DATA_SELECT_HI 2
`define USC_PARITY_DATA_SELECT_LO 1
`define USC_STA_RST 16'h0110
`define USC_MODE_RST 16'h0000
`endif

// ==== rtl/usc_pkg.sv ====
// types shared by the serial status and control block
package usc_pkg;
  typedef logic [8:0] usc_char_t;
  typedef enum logic [1:0] {
    USC_TXI_LOAD = 2'h0,
    USC_TXI_DONE = 2'h1,
    USC_TXI_EMPTY = 2'h2,
    USC_TXI_RSVD = 2'h3
  } usc_txisel_t;
  typedef enum logic [1:0] {
    USC_TX_IDLE,
    USC_TX_CHAR,
    USC_TX_BREAK
  } usc_tx_state_t;
endpackage

// ==== rtl/usc_fifo.sv ====
// four-entry character buffer with flush
`include "usc_defs.svh"
module usc_fifo #(
  parameter int W = 9
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic push_i,
  input wire logic pop_i,
  input wire logic flush_i,
  input wire logic [W-1:0] data_i,
  output logic [W-1:0] head_o,
  output logic [2:0] count_o,
  output logic full_o,
  output logic empty_o
);
  logic [W-1:0] mem [4];
  logic [1:0] wp;
  logic [1:0] rp;
  logic [2:0] cnt;
  logic wr;
  logic rd;

  assign wr = push_i && (cnt != `USC_DEPTH);
  assign rd = pop_i && (cnt != 3'h0);

  always_ff @(posedge clk_i) begin
    if (rst_i || flush_i) begin
      wp <= 2'h0;
      rp <= 2'h0;
      cnt <= 3'h0;
    end else begin
      if (wr) begin
        wp <= wp + 2'h1;
      end
      if (rd) begin
        rp <= rp + 2'h1;
      end
      cnt <= cnt + {2'h0, wr} - {2'h0, rd};
    end
  end

  always_ff @(posedge clk_i) begin
    if (wr && !flush_i) begin
      mem[wp] <= data_i;
    end
  end

  assign head_o = mem[rp];
  assign count_o = cnt;
  assign full_o = (cnt == `USC_DEPTH);
  assign empty_o = (cnt == 3'h0);
endmodule

// ==== rtl/usc_top.sv ====
// serial port status and control register with its buffers and events
// Notes on behaviour
// [RL1] selector 10: interrupt when a load into shifter empties the buffer
// [RL2] selector 01: interrupt when the last character has fully left
// [RL3] selector 00: interrupt on every load into the shifter
// [RL4] software never writes the reserved selector code 11
// [RL5] idle level: encoder off, set bit idles low; encoder on, idles high
// [RL6] break request sends break on next load, then clears itself
// [RL7] transmit enable owns the pin; clearing it aborts and flushes
// [RL8] buffer full flag is one when no slot is free
// [RL9] all-empty flag is one when shifter and buffer are empty
// [RL10] receive selector 11: interrupt when buffer reaches four characters
// [RL11] receive selector 10: interrupt when buffer reaches three characters
// [RL12] receive selector 0x: interrupt on every character received
// [RL13] address detect marks ninth-bit-set characters, only in nine-bit mode
// [RL14] receiver idle flag is one when idle, resets to one
// [RL15] parity error flag belongs to the head character
// [RL16] framing error flag belongs to the head character
// [RL17] overrun sets on overflow; clearing it empties buffer and shifter
// [RL18] data available is one while an unread character waits
// [RL19] reading receive data advances the head with its own flags
// [RL20] format code 11 is nine data bits without parity
// [RL21] infrared enable turns on the encoder and decoder
// [RL22] address mode drops characters whose ninth bit is zero
// [RL23] status follows events within one clock; read-only writes ignored
//
// Our own choices: the placing of the registers and the Wishbone slave port.
`include "usc_defs.svh"
module usc_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic tx_load_o,
  output usc_pkg::usc_char_t tx_char_o,
  output logic tx_break_o,
  input wire logic tx_done_i,
  output logic tx_abort_o,
  output logic tx_pin_own_o,
  output logic tx_idle_level_o,
  output logic tx_irq_o,
  input wire logic rx_push_i,
  input wire usc_pkg::usc_char_t rx_char_i,
  input wire logic rx_parity_error_flag_i,
  input wire logic rx_framing_error_flag_i,
  input wire logic rx_active_i,
  output logic rx_flush_o,
  output logic rx_irq_o,
  output logic infrared_enable_o,
  output logic [1:0] parity_data_select_o
);
  import usc_pkg::*;
  usc_txisel_t tx_irq_select;
  logic tx_idle_polarity;
  logic break_request;
  logic tx_enable_bit;
  logic [1:0] rx_irq_select;
  logic addr_detect_enable;
  logic overrun_flag;
  logic infrared_enable;
  logic [1:0] parity_data_select;
  usc_tx_state_t tx_state;
  logic req, wr, rd;
  logic wr_sta, wr_txd, rd_rxd, wr_mode;
  logic [15:0] sta;
  logic tx_push, tx_pop, tx_flush, tx_full, tx_empty, load_go, tx_stop;
  logic [2:0] tx_count;
  usc_char_t tx_head;
  logic rx_take, rx_ovf, rx_push, rx_pop, rx_clr, rx_full, rx_empty;
  logic [2:0] rx_count;
  logic [10:0] rx_head;
  logic addr_mode, tx_all_empty;
  // fill level after a push with or without a pop in the same cycle
  function automatic logic [2:0] fill_after(input logic [2:0] c,
                                            input logic p);
    fill_after = c + 3'h1 - {2'h0, p};
  endfunction
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = req && wb_we_i;
  assign rd = req && !wb_we_i;
  assign wr_sta = wr && (wb_adr_i == `USC_ADR_STA);
  assign wr_txd = wr && (wb_adr_i == `USC_ADR_TXD) && wb_sel_i[0];
  assign rd_rxd = rd && (wb_adr_i == `USC_ADR_RXD);
  assign wr_mode = wr && (wb_adr_i == `USC_ADR_MODE);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end
  // control fields; only writable positions are taken
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_irq_select <= USC_TXI_LOAD;
      tx_idle_polarity <= 1'b0;
      tx_enable_bit <= 1'b0;
      rx_irq_select <= 2'h0;
      addr_detect_enable <= 1'b0;
    end else if (wr_sta) begin // [RL23]
      if (wb_sel_i[1]) begin
        tx_irq_select <= usc_txisel_t'({wb_dat_i[`USC_TXISEL_HI],
                                        wb_dat_i[`USC_TXISEL_LO]});
        tx_idle_polarity <= wb_dat_i[`USC_TXINV];
        tx_enable_bit <= wb_dat_i[`USC_TXEN];
      end
      if (wb_sel_i[0]) begin
        rx_irq_select <= wb_dat_i[`USC_RXISEL_HI:`USC_RXISEL_LO];
        addr_detect_enable <= wb_dat_i[`USC_ADDR_DETECT_ENABLE];
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      infrared_enable <= 1'b0;
      parity_data_select <= 2'h0;
    end else if (wr_mode) begin
      if (wb_sel_i[1]) begin
        infrared_enable <= wb_dat_i[`USC_INFRARED_ENABLE]; // [RL21]
      end
      if (wb_sel_i[0]) begin
        parity_data_select <= wb_dat_i[`USC_PARITY_DATA_SELECT_HI:`USC_PARITY_DATA_SELECT_LO];
      end
    end
  end
  assign infrared_enable_o = infrared_enable;
  assign parity_data_select_o = parity_data_select;
  // transmit side
  assign tx_stop = wr_sta && wb_sel_i[1] && tx_enable_bit &&
                   !wb_dat_i[`USC_TXEN];
  assign tx_flush = tx_stop; // [RL7]
  assign tx_push = wr_txd;
  assign load_go = tx_enable_bit && !tx_stop &&
                   (tx_state == USC_TX_IDLE) && !tx_empty;
  assign tx_pop = load_go;
  usc_fifo #(.W(9)) u_tx_buf (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .push_i(tx_push),
    .pop_i(tx_pop),
    .flush_i(tx_flush),
    .data_i(wb_dat_i[8:0]),
    .head_o(tx_head),
    .count_o(tx_count),
    .full_o(tx_full),
    .empty_o(tx_empty)
  );
  always_ff @(posedge clk_i) begin
    if (rst_i || tx_stop) begin // [RL7]
      tx_state <= USC_TX_IDLE;
    end else begin
      case (tx_state)
        USC_TX_IDLE: begin
          if (load_go) begin
            tx_state <= break_request ? USC_TX_BREAK : USC_TX_CHAR;
          end
        end
        USC_TX_CHAR, USC_TX_BREAK: begin
          if (tx_done_i) begin
            tx_state <= USC_TX_IDLE;
          end
        end
        default: tx_state <= USC_TX_IDLE;
      endcase
    end
  end
  // a software write in the same cycle wins over the hardware clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      break_request <= 1'b0;
    end else if (wr_sta && wb_sel_i[1]) begin
      break_request <= wb_dat_i[`USC_BRK];
    end else if (tx_state == USC_TX_BREAK && tx_done_i) begin
      break_request <= 1'b0; // [RL6]
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_load_o <= 1'b0;
      tx_char_o <= 9'h000;
      tx_break_o <= 1'b0;
      tx_abort_o <= 1'b0;
    end else begin
      tx_load_o <= load_go;
      tx_abort_o <= tx_stop; // [RL7]
      if (load_go) begin
        tx_char_o <= tx_head;
        tx_break_o <= break_request; // [RL6]
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_irq_o <= 1'b0;
    end else begin
      case (tx_irq_select)
        USC_TXI_LOAD: tx_irq_o <= load_go; // [RL3]
        USC_TXI_EMPTY: tx_irq_o <= load_go && tx_count == 3'h1 &&
                                   !tx_push; // [RL1]
        USC_TXI_DONE: tx_irq_o <= tx_done_i && tx_state != USC_TX_IDLE &&
                                  tx_empty && !tx_push; // [RL2]
        default: tx_irq_o <= 1'b0; // [RL4]
      endcase
    end
  end
  assign tx_pin_own_o = tx_enable_bit; // [RL7]
  assign tx_idle_level_o = infrared_enable ? tx_idle_polarity
                                           : !tx_idle_polarity; // [RL5]
  assign tx_all_empty = (tx_state == USC_TX_IDLE) && tx_empty; // [RL9]
  // receive side
  assign addr_mode = addr_detect_enable &&
                     (parity_data_select == 2'h3); // [RL13] [RL20]
  assign rx_take = rx_push_i && !(addr_mode && !rx_char_i[8]); // [RL22]
  assign rx_ovf = rx_take && rx_full;
  assign rx_push = rx_take && !rx_full;
  assign rx_pop = rd_rxd && !rx_empty; // [RL19]
  assign rx_clr = wr_sta && wb_sel_i[0] && overrun_flag &&
                  !wb_dat_i[`USC_OVERRUN_FLAG] && !rx_ovf;
  usc_fifo #(.W(11)) u_rx_buf (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .push_i(rx_push),
    .pop_i(rx_pop),
    .flush_i(rx_clr),
    .data_i({rx_framing_error_flag_i, rx_parity_error_flag_i, rx_char_i}),
    .head_o(rx_head),
    .count_o(rx_count),
    .full_o(rx_full),
    .empty_o(rx_empty)
  );
  // overflow wins over a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      overrun_flag <= 1'b0;
      rx_flush_o <= 1'b0;
    end else begin
      rx_flush_o <= rx_clr; // [RL17]
      if (rx_ovf) begin
        overrun_flag <= 1'b1; // [RL17]
      end else if (rx_clr) begin
        overrun_flag <= 1'b0;
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_irq_o <= 1'b0;
    end else begin
      case (rx_irq_select)
        2'h3: rx_irq_o <= rx_push &&
                          fill_after(rx_count, rx_pop) == 3'h4; // [RL10]
        2'h2: rx_irq_o <= rx_push &&
                          fill_after(rx_count, rx_pop) == 3'h3; // [RL11]
        default: rx_irq_o <= rx_push; // [RL12]
      endcase
    end
  end
  always_comb begin
    sta = 16'h0000;
    sta[`USC_TXISEL_HI] = tx_irq_select[1];
    sta[`USC_TXISEL_LO] = tx_irq_select[0];
    sta[`USC_TXINV] = tx_idle_polarity;
    sta[`USC_BRK] = break_request;
    sta[`USC_TXEN] = tx_enable_bit;
    sta[`USC_TXBF] = tx_full; // [RL8]
    sta[`USC_TX_ALL_EMPTY] = tx_all_empty; // [RL9]
    sta[`USC_RXISEL_HI:`USC_RXISEL_LO] = rx_irq_select;
    sta[`USC_ADDR_DETECT_ENABLE] = addr_detect_enable;
    sta[`USC_RX_IDLE_FLAG] = !rx_active_i; // [RL14]
    sta[`USC_PARITY_ERROR_FLAG] = !rx_empty && rx_head[9]; // [RL15]
    sta[`USC_FRAMING_ERROR_FLAG] = !rx_empty && rx_head[10]; // [RL16]
    sta[`USC_OVERRUN_FLAG] = overrun_flag;
    sta[`USC_RXDA] = !rx_empty; // [RL18]
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (rd) begin
      case (wb_adr_i)
        `USC_ADR_STA: wb_dat_o <= {16'h0000, sta};
        `USC_ADR_RXD: wb_dat_o <= rx_empty ? 32'h0000_0000 :
                                  {23'h000000, rx_head[8:0]}; // [RL19]
        `USC_ADR_MODE: wb_dat_o <= {16'h0000, 3'h0, infrared_enable,
                                    9'h000, parity_data_select, 1'b0};
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence break_load_s;
    load_go && break_request && !(wr_sta && wb_sel_i[1]);
  endsequence
  sequence break_end_s;
    tx_state == USC_TX_BREAK && tx_done_i && !(wr_sta && wb_sel_i[1]);
  endsequence
  tx_load_irq_a: assert property ( // [RL3]
    load_go && tx_irq_select == USC_TXI_LOAD |=> tx_irq_o)
    else $error("no transmit interrupt on load");
  tx_empty_irq_a: assert property ( // [RL1]
    tx_irq_o && $past(tx_irq_select) == USC_TXI_EMPTY |->
      tx_load_o && tx_empty)
    else $error("empty interrupt with buffer not empty");
  tx_done_irq_a: assert property ( // [RL2]
    tx_irq_o && $past(tx_irq_select) == USC_TXI_DONE |->
      $past(tx_done_i) && tx_all_empty)
    else $error("done interrupt before transmit complete");
  break_clear_a: assert property ( // [RL6]
    break_load_s ##1 tx_break_o ##[0:1000] break_end_s |=> !break_request)
    else $error("break request not cleared after break");
  tx_abort_a: assert property ( // [RL7]
    tx_stop |=> tx_abort_o && tx_empty && !tx_pin_own_o && !tx_load_o)
    else $error("transmit disable did not abort");
  tx_all_empty_busy_a: assert property ( // [RL9]
    tx_load_o |-> !sta[`USC_TX_ALL_EMPTY] && sta[`USC_TXBF] == (tx_count == 3'h4))
    else $error("empty or full flag wrong during load");
  idle_level_a: assert property ( // [RL5]
    tx_idle_level_o == (infrared_enable == tx_idle_polarity))
    else $error("transmit idle level wrong");
  rx_fill_irq_a: assert property ( // [RL10]
    rx_irq_o && $past(rx_irq_select) == 2'h3 |-> rx_count == 3'h4)
    else $error("full interrupt at wrong fill");
  addr_drop_a: assert property ( // [RL22]
    rx_push_i && addr_mode && !rx_char_i[8] && !rx_pop && !rx_clr |=>
      rx_count == $past(rx_count))
    else $error("data character kept in address mode");
  overrun_a: assert property ( // [RL17]
    rx_push_i && rx_full && !(addr_mode && !rx_char_i[8]) |=>
      overrun_flag ##1 (overrun_flag || $past(rx_clr)))
    else $error("overrun not flagged");
  rx_pop_a: assert property ( // [RL19]
    rd_rxd && rx_count == 3'h2 && !rx_push |=> rx_count == 3'h1 && wb_ack_o)
    else $error("receive read did not advance head");
endmodule

// ==== sim/usc_far.sv ====
// far-side shifter model: times transmit loads and delivers received chars
module usc_far (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tx_load_o,
  input wire usc_pkg::usc_char_t tx_char_o,
  input wire logic tx_break_o,
  input wire logic tx_abort_o,
  output logic tx_done_i,
  output logic rx_push_i,
  output usc_pkg::usc_char_t rx_char_i,
  output logic rx_parity_error_flag_i,
  output logic rx_framing_error_flag_i,
  output logic rx_active_i
);
  timeunit 1ns;
  timeprecision 1ps;
  import usc_pkg::*;
  int dly = 6;
  int cnt = 0;
  logic act = 1'b0;
  logic brk = 1'b0;
  usc_char_t last = '0;
  initial begin
    tx_done_i = 1'b0;
    rx_push_i = 1'b0;
    rx_char_i = '0;
    rx_parity_error_flag_i = 1'b0;
    rx_framing_error_flag_i = 1'b0;
  end
  assign rx_active_i = act;
  always @(posedge clk_i) begin
    tx_done_i <= 1'b0;
    if (rst_i || tx_abort_o) begin
      cnt <= 0;
    end else if (tx_load_o) begin
      cnt <= dly;
      last <= tx_char_o;
      brk <= tx_break_o;
    end else if (cnt == 1) begin
      cnt <= 0;
      tx_done_i <= 1'b1;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
  // one character per push; lines show the inverse once the push is over
  task automatic send(input usc_char_t c, input logic pe, input logic fe);
    @(posedge clk_i);
    rx_push_i <= 1'b1;
    rx_char_i <= c;
    rx_parity_error_flag_i <= pe;
    rx_framing_error_flag_i <= fe;
    @(posedge clk_i);
    rx_push_i <= 1'b0;
    rx_char_i <= ~c;
    rx_parity_error_flag_i <= ~pe;
    rx_framing_error_flag_i <= ~fe;
  endtask
endmodule

// ==== sim/testbench.sv ====
// self-checking bench for the serial status and control block
`include "usc_defs.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import usc_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, tx_load_o, tx_break_o, tx_done_i, tx_abort_o;
  logic tx_pin_own_o, tx_idle_level_o, tx_irq_o, rx_push_i, rx_parity_error_flag_i;
  logic rx_framing_error_flag_i, rx_active_i, rx_flush_o, rx_irq_o, infrared_enable_o;
  logic [1:0] parity_data_select_o;
  usc_char_t tx_char_o, rx_char_i;
  int n_errors = 0;
  int checked = 0;
  int n_txi = 0;
  int n_rxi = 0;
  int n_ld = 0;
  int n_ab = 0;
  int n_fl = 0;
  logic [15:0] ctl = 16'h0;
  logic [15:0] q;
  always #2.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    n_txi += int'(tx_irq_o);
    n_rxi += int'(rx_irq_o);
    n_ld += int'(tx_load_o);
    n_ab += int'(tx_abort_o);
    n_fl += int'(rx_flush_o);
  end
  usc_top i_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .tx_load_o, .tx_char_o,
    .tx_break_o, .tx_done_i, .tx_abort_o, .tx_pin_own_o, .tx_idle_level_o,
    .tx_irq_o, .rx_push_i, .rx_char_i, .rx_parity_error_flag_i, .rx_framing_error_flag_i, .rx_active_i,
    .rx_flush_o, .rx_irq_o, .infrared_enable_o, .parity_data_select_o);
  usc_far i_far (.clk_i, .rst_i, .tx_load_o, .tx_char_o, .tx_break_o,
    .tx_abort_o, .tx_done_i, .rx_push_i, .rx_char_i, .rx_parity_error_flag_i, .rx_framing_error_flag_i,
    .rx_active_i);
  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= 4'h3;
    wb_dat_i <= {16'h0000, d};
    // only the watchdog ends a wait for the acknowledge
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o[15:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic sta(input logic [15:0] v);
    ctl = v;
    wb(1'b1, `USC_ADR_STA, v);
  endtask
  task automatic rs;
    wb(1'b0, `USC_ADR_STA, 16'h0);
  endtask
  task automatic poll;
    int k;
    k = 0;
    do begin
      rs();
      k++;
    end while (q[`USC_TX_ALL_EMPTY] !== 1'b1 && k < 100);
    if (q[`USC_TX_ALL_EMPTY] !== 1'b1) begin
      n_errors++;
      $display("[FAIL] all empty expected 1 seen %b", q[`USC_TX_ALL_EMPTY]);
      end_of_test();
    end
    repeat (3) @(posedge clk_i);
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #200000;
    n_errors++;
    $display("[FAIL] watchdog expected end of tests seen timeout");
    end_of_test();
  end
  initial begin
    int b;
    int c;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rs();
    chk("status reset", `USC_STA_RST, q);
    chk("idle level", 16'h1, tx_idle_level_o);
    wb(1'b1, `USC_ADR_STA, 16'h1307);
    rs();
    chk("read-only bits", `USC_STA_RST, q);
    wb(1'b0, 8'h10, 16'h0);
    chk("unmapped read", 16'h0, q);
    wb(1'b0, `USC_ADR_RXD, 16'h0);
    chk("empty rx read", 16'h0, q);
    $display("reset test done");
    for (int m = 0; m < 4; m++) begin
      wb(1'b1, `USC_ADR_MODE, 16'(m[1]) << `USC_INFRARED_ENABLE);
      sta(16'(m[0]) << `USC_TXINV);
      chk("idle level", m[1] ? m[0] : !m[0], tx_idle_level_o);
      chk("infrared", m[1], infrared_enable_o);
    end
    wb(1'b1, `USC_ADR_MODE, 16'h0);
    $display("polarity test done");
    // selector 11 is reserved and never written here
    sta(16'h1 << `USC_TXEN);
    chk("pin owned", 16'h1, tx_pin_own_o);
    repeat (4) @(posedge clk_i);
    for (int s = 0; s < 3; s++) begin
      sta((16'h1 << `USC_TXEN) | (16'(s[1]) << `USC_TXISEL_HI)
        | (16'(s[0]) << `USC_TXISEL_LO));
      b = n_txi;
      c = n_ld;
      for (int i = 0; i < 3; i++) wb(1'b1, `USC_ADR_TXD, 16'h0a0 + 16'(i));
      poll();
      chk("tx irq count", s == 0 ? 3 : s == 1 ? 1 : 2, n_txi - b);
      chk("tx loads", 16'h3, n_ld - c);
      chk("last char", 16'h0a2, i_far.last);
    end
    $display("tx interrupt test done");
    sta(ctl | (16'h1 << `USC_BRK));
    wb(1'b1, `USC_ADR_TXD, 16'h01ff);
    poll();
    chk("break sent", 16'h1, i_far.brk);
    chk("break cleared", 16'h0, q[`USC_BRK]);
    wb(1'b1, `USC_ADR_TXD, 16'h0055);
    poll();
    chk("plain after break", 16'h0, i_far.brk);
    $display("break test done");
    i_far.dly = 40;
    b = n_ab;
    c = n_ld;
    for (int i = 0; i < 6; i++) wb(1'b1, `USC_ADR_TXD, 16'h010 + 16'(i));
    rs();
    chk("buffer full", 16'h1, q[`USC_TXBF]);
    chk("all empty", 16'h0, q[`USC_TX_ALL_EMPTY]);
    // the break request bit must not be written back here
    sta(ctl & ~((16'h1 << `USC_TXEN) | (16'h1 << `USC_BRK)));
    @(posedge clk_i);
    chk("pin owned", 16'h0, tx_pin_own_o);
    chk("abort", 16'h1, n_ab - b);
    rs();
    chk("full after abort", 16'h0, q[`USC_TXBF]);
    chk("empty after abort", 16'h1, q[`USC_TX_ALL_EMPTY]);
    chk("break idle", 16'h0, q[`USC_BRK]);
    chk("loads", 16'h1, n_ld - c);
    i_far.dly = 6;
    $display("abort test done");
    for (int s = 0; s < 4; s++) begin
      sta(16'(s) << `USC_RXISEL_LO);
      b = n_rxi;
      for (int i = 0; i < 4; i++) i_far.send(9'h100 + 9'(i), i[0], i[1]);
      repeat (2) @(posedge clk_i);
      chk("rx irq count", s < 2 ? 4 : 1, n_rxi - b);
      if (s == 3) begin
        c = n_fl;
        i_far.send(9'h0ff, 1'b0, 1'b0);
        rs();
        chk("overrun", 16'h1, q[`USC_OVERRUN_FLAG]);
        sta(ctl);
        @(posedge clk_i);
        chk("flush", 16'h1, n_fl - c);
      end else begin
        for (int i = 0; i < 4; i++) begin
          rs();
          chk("data avail", 16'h1, q[`USC_RXDA]);
          chk("parity", i[0], q[`USC_PARITY_ERROR_FLAG]);
          chk("framing", i[1], q[`USC_FRAMING_ERROR_FLAG]);
          wb(1'b0, `USC_ADR_RXD, 16'h0);
          chk("rx data", 16'h100 + 16'(i), q);
        end
      end
      rs();
      chk("data avail", 16'h0, q[`USC_RXDA]);
      chk("overrun", 16'h0, q[`USC_OVERRUN_FLAG]);
    end
    $display("receive test done");
    i_far.act <= 1'b1;
    rs();
    chk("rx idle", 16'h0, q[`USC_RX_IDLE_FLAG]);
    i_far.act <= 1'b0;
    // address detect has no effect outside the nine-bit format
    sta(16'h1 << `USC_ADDR_DETECT_ENABLE);
    i_far.send(9'h055, 1'b0, 1'b0);
    wb(1'b0, `USC_ADR_RXD, 16'h0);
    chk("eight-bit kept", 16'h0055, q);
    wb(1'b1, `USC_ADR_MODE, 16'h0006);
    chk("format", 16'h3, parity_data_select_o);
    wb(1'b0, `USC_ADR_MODE, 16'h0);
    chk("mode read", 16'h0006, q);
    i_far.send(9'h055, 1'b0, 1'b0);
    rs();
    chk("data dropped", 16'h0, q[`USC_RXDA]);
    i_far.send(9'h1a5, 1'b0, 1'b0);
    rs();
    chk("address kept", 16'h1, q[`USC_RXDA]);
    wb(1'b0, `USC_ADR_RXD, 16'h0);
    chk("address char", 16'h01a5, q);
    $display("address test done");
    end_of_test();
  end
endmodule
